// [logic/sadc_defines.vh]
// sadc_defines.vh: register map, field positions, reset values and timing for the converter control
// assumes: included by the converter control design, monitor and bench files
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH
// ==========================================================================
// register byte addresses (word aligned index times four)
`define SADC_IDX_MODE 16'hff80
`define SADC_IDX_CHAN 16'hff81
`define SADC_IDX_RESULT 16'hff18
`define SADC_ADDR_MODE 18'h3fe00
`define SADC_ADDR_CHAN 18'h3fe04
`define SADC_ADDR_RESULT 18'h3fc60
`define SADC_ADDR_STATUS 18'h3fc64
// ==========================================================================
// mode and channel register fields and reset values
`define SADC_MODE_RUN 7
`define SADC_MODE_SRC 6
`define SADC_MODE_TIME_HI 5
`define SADC_MODE_TIME_LO 3
`define SADC_MODE_EDGE_HI 2
`define SADC_MODE_EDGE_LO 1
`define SADC_CHAN_HI 2
`define SADC_MODE_RST 8'h00
`define SADC_CHAN_RST 8'h00
// ==========================================================================
// conversion lengths in system clock cycles
`define SADC_CYC_144 8'h90
`define SADC_CYC_120 8'h78
`define SADC_CYC_96 8'h60
`define SADC_CYC_72 8'h48
`define SADC_CYC_60 8'h3c
`define SADC_CYC_48 8'h30
// sampling share is one eighth of the conversion
`define SADC_SAMPLE_SHIFT 3
`endif

// [logic/sadc_sync3.v]
// sadc_sync3.v: three-stage synchroniser with agreement filter
// assumes: single clock, synchronous active-high reset
module sadc_sync3 (
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // asynchronous level in, filtered level out
  input wire i_async,
  output wire o_level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg level_ff;
  // ==========================================================================
  // shift chain; level changes once stages two and three agree
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end
  assign o_level = level_ff;
endmodule // sadc_sync3

// [logic/sadc_trig_edge.v]
// sadc_trig_edge.v: qualifies a synchronised trigger level by the edge field
// assumes: input already synchronised to i_ref_clk
`include "sadc_defines.vh"
module sadc_trig_edge (
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // synchronised level and edge field
  input wire i_level,
  input wire [1:0] i_edge_sel,
  // one-cycle start pulse
  output wire o_pulse
);
  reg prev_ff;
  wire rise;
  wire fall;
  // ==========================================================================
  // previous level for edge detection
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= i_level;
    end
  end
  assign rise = i_level & ~prev_ff;
  assign fall = ~i_level & prev_ff;
  // edge code 01 fall, 10 rise, 11 both, 00 none
  assign o_pulse = (i_edge_sel[1] & rise) | (i_edge_sel[0] & fall);
endmodule // sadc_trig_edge

// [logic/sadc_ctrl.v]
// sadc_ctrl.v: control for an eight-channel 10-bit successive-approximation converter
// assumes: AHB-Lite single word transfers, analogue comparator on i_cmp_high, one 10 MHz clock
// Operation
// - mode bit 7 halts or enables conversion
// - mode bit 6 selects software or trigger start
// - time field sets 144 to 48 cycles
// - edge field selects none, fall, rise, both
// - channel low three bits select input
// - reset clears mode and channel registers
// - sample fixed interval, then hold until done
// - first trial bit 9 at half reference
// - bit 8 trial at quarter taps
// - down to bit 0, store, pulse interrupt
// - software mode converts back to back
// - mode or channel write aborts, restarts
// - hardware mode waits for qualified trigger
// - one conversion per trigger edge
// - channel write in hardware mode rewaits
// - clearing run stops conversion at once
// - result left-aligned 16 bits, low six zero
// - register write beats completion
// - triggers ignored during conversion
// - read first, then result update
`include "sadc_defines.vh"
module sadc_ctrl (
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // ahb-lite slave
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  // trigger pin
  input wire i_ext_trigger,
  // analogue front end
  input wire i_cmp_high,
  output wire [2:0] o_chan_sel,
  output wire o_sample,
  output wire [9:0] o_tap_code,
  // completion event
  output wire o_conv_done_irq
);
  // controller states
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_SAMPLE = 2'b10;
  localparam ST_TRIAL = 2'b11;

  // control, result and sequencing registers
  reg [7:0] mode_ff;
  reg [7:0] chan_ff;
  reg [9:0] result_ff;
  reg [9:0] sar_ff;
  reg [3:0] bit_ff;
  reg [1:0] state_ff;
  reg [7:0] cnt_ff;
  reg [4:0] step_ff;
  reg irq_ff;
  reg pend_ff;
  reg [9:0] pend_val_ff;
  reg [31:0] rdata_ff;
  reg aph_wr_ff;
  reg [17:0] aph_addr_ff;
  // combinational decode
  reg [1:0] nxt_state;
  reg [7:0] conv_len;
  reg [31:0] rd_mux;
  // trigger, bus decode and trial timing
  wire trig_level;
  wire trig_pulse;
  wire run;
  wire hw_mode;
  wire mode_wr;
  wire chan_wr;
  wire reg_wr;
  wire res_rd;
  wire aph_take;
  wire [7:0] sample_len;
  wire [4:0] trial_len;
  wire [9:0] trial_val;
  wire trial_end;
  wire conv_end;
  wire [9:0] final_val;
  wire [7:0] trial_span;
  wire sample_end;
  wire done_ok;

  // ==========================================================================
  // trigger synchroniser and edge qualifier
  // three-stage filter on the pin
  sadc_sync3 u_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_async(i_ext_trigger),
    .o_level(trig_level)
  );
  // one-cycle pulse per qualified edge
  sadc_trig_edge u_edge (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_level(trig_level),
    .i_edge_sel(mode_ff[`SADC_MODE_EDGE_HI:`SADC_MODE_EDGE_LO]),
    .o_pulse(trig_pulse)
  );

  // ==========================================================================
  // bus slave: address phase capture, zero wait states
  // address phase accepted when selected, ready and the transfer is neither idle nor busy
  assign aph_take = i_hsel & i_hready & i_htrans[1];
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      aph_wr_ff <= 1'b0;
      aph_addr_ff <= 18'h00000;
    end else begin
      aph_wr_ff <= aph_take & i_hwrite;
      aph_addr_ff <= i_haddr[17:0];
    end
  end
  // data-phase write strobes
  assign mode_wr = aph_wr_ff & (aph_addr_ff == `SADC_ADDR_MODE);
  assign chan_wr = aph_wr_ff & (aph_addr_ff == `SADC_ADDR_CHAN);
  assign reg_wr = mode_wr | chan_wr;
  // read of result in its address phase
  assign res_rd = aph_take & ~i_hwrite & (i_haddr[17:0] == `SADC_ADDR_RESULT);
  // zero wait states, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_ff;

  // register chosen by the address phase; unmapped reads give zero
  always @* begin
    case (i_haddr[17:0])
      `SADC_ADDR_MODE: rd_mux = {24'h000000, mode_ff};
      `SADC_ADDR_CHAN: rd_mux = {29'h00000000, chan_ff[`SADC_CHAN_HI:0]};
      `SADC_ADDR_RESULT: rd_mux = {16'h0000, result_ff, 6'h00};
      `SADC_ADDR_STATUS: rd_mux = {30'h00000000, state_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end
  // read data registered at address phase, so it stands in the data phase
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_ff <= 32'h00000000;
    end else if (aph_take & ~i_hwrite) begin
      rdata_ff <= rd_mux;
    end
  end

  // ==========================================================================
  // control registers
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      mode_ff <= `SADC_MODE_RST;
      chan_ff <= `SADC_CHAN_RST;
    end else begin
      if (mode_wr) begin
        mode_ff <= {i_hwdata[7:1], 1'b0};
      end
      if (chan_wr) begin
        chan_ff <= {5'h00, i_hwdata[`SADC_CHAN_HI:0]};
      end
    end
  end
  // decoded mode and channel fields
  assign run = mode_ff[`SADC_MODE_RUN];
  assign hw_mode = mode_ff[`SADC_MODE_SRC];
  assign o_chan_sel = chan_ff[`SADC_CHAN_HI:0];

  // ==========================================================================
  // conversion length from time field; prohibited codes fall back to longest
  // time field is read live; software halts before changing it
  always @* begin
    case (mode_ff[`SADC_MODE_TIME_HI:`SADC_MODE_TIME_LO])
      3'h0: conv_len = `SADC_CYC_144;
      3'h1: conv_len = `SADC_CYC_120;
      3'h2: conv_len = `SADC_CYC_96;
      3'h4: conv_len = `SADC_CYC_72;
      3'h5: conv_len = `SADC_CYC_60;
      3'h6: conv_len = `SADC_CYC_48;
      default: conv_len = `SADC_CYC_144;
    endcase
  end
  // sampling takes one eighth, the rest split over ten trials
  assign sample_len = conv_len >> `SADC_SAMPLE_SHIFT;
  assign trial_span = (conv_len - sample_len) / 8'h0a;
  // longest trial is twelve cycles, so five bits hold it
  assign trial_len = trial_span[4:0];

  // ==========================================================================
  // state sequencing
  assign sample_end = (state_ff == ST_SAMPLE) & (cnt_ff == sample_len - 8'h01);
  assign trial_end = (state_ff == ST_TRIAL) & (step_ff == trial_len - 5'h01);
  assign conv_end = trial_end & (bit_ff == 4'h0);
  // next state; run clear and register writes override the sequence
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (run) begin
          nxt_state = hw_mode ? ST_WAIT : ST_SAMPLE;
        end
      end
      ST_WAIT: begin
        if (trig_pulse) begin
          nxt_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (sample_end) begin
          nxt_state = ST_TRIAL;
        end
      end
      ST_TRIAL: begin
        if (conv_end) begin
          nxt_state = hw_mode ? ST_WAIT : ST_SAMPLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // clearing run stops at once; writes abort and reinitialise
    if (!run) begin
      nxt_state = ST_IDLE;
    end else if (reg_wr) begin
      nxt_state = ST_IDLE;
    end
  end

  // trial value: current bit set on top of decided bits
  assign trial_val = sar_ff | (10'h001 << bit_ff);
  // keep the bit when the comparator reports input at or above the tap
  assign final_val = i_cmp_high ? trial_val : sar_ff;

  // state, counters and approximation value
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      step_ff <= 5'h00;
      bit_ff <= 4'h9;
      sar_ff <= 10'h000;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        cnt_ff <= 8'h00;
        step_ff <= 5'h00;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
        step_ff <= (state_ff == ST_TRIAL) ? step_ff + 5'h01 : 5'h00;
      end
      if (state_ff != ST_TRIAL) begin
        bit_ff <= 4'h9;
        sar_ff <= 10'h000;
      end else if (trial_end) begin
        // keep bit when input at or above the tap
        sar_ff <= final_val;
        bit_ff <= bit_ff - 4'h1;
        step_ff <= 5'h00;
      end
    end
  end
  // front-end controls: sample level and trial tap
  assign o_sample = (state_ff == ST_SAMPLE);
  assign o_tap_code = (state_ff == ST_TRIAL) ? trial_val : 10'h000;

  // ==========================================================================
  // a completion counts only while running and with no register write
  assign done_ok = conv_end & run & ~reg_wr;
  // result store and completion pulse; a same-cycle result read delays update
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      result_ff <= 10'h000;
      irq_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_val_ff <= 10'h000;
    end else begin
      irq_ff <= done_ok;
      if (done_ok & res_rd) begin
        pend_ff <= 1'b1;
        pend_val_ff <= final_val;
      end else if (done_ok) begin
        result_ff <= final_val;
        pend_ff <= 1'b0;
      end else if (pend_ff) begin
        result_ff <= pend_val_ff;
        pend_ff <= 1'b0;
      end
    end
  end
  // completion pulse straight from its flop
  assign o_conv_done_irq = irq_ff;
endmodule // sadc_ctrl

// [sim/sadc_ctrl_monitor.sv]
// sadc_ctrl_monitor.sv: port assertions for the converter control
// assumes: bound into sadc_ctrl, one clock, synchronous active-high reset
`include "sadc_defines.vh"
module sadc_ctrl_monitor (
  // clock, reset and bus
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  // converter side
  input wire logic i_cmp_high,
  input wire logic [2:0] o_chan_sel,
  input wire logic o_sample,
  input wire logic [9:0] o_tap_code,
  input wire logic o_conv_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====
  // data phase flags of register writes
  logic wr_mode_ff;
  logic wr_chan_ff;
  logic halt_ff;
  wire wr_go = i_hsel && i_hready && i_htrans[1] && i_hwrite;
  always_ff @(posedge i_ref_clk) begin
    wr_mode_ff <= !i_srst && wr_go && i_haddr[17:0] == `SADC_ADDR_MODE;
    wr_chan_ff <= !i_srst && wr_go && i_haddr[17:0] == `SADC_ADDR_CHAN;
  end
  // halted from reset or a run-clear mode write until run is written back
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      halt_ff <= 1'b1;
    end else if (wr_mode_ff) begin
      halt_ff <= !i_hwdata[7];
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  a_reset_clears: assert property (disable iff (1'b0)
    i_srst |=> o_chan_sel == 3'h0 && !o_sample && !o_conv_done_irq) else $error("outputs active after reset");
  a_chan_follows: assert property (
    wr_chan_ff |=> o_chan_sel == $past(i_hwdata[2:0])) else $error("channel output not written value");
  a_write_aborts: assert property (
    wr_mode_ff || wr_chan_ff |=> !o_sample && o_tap_code == 10'h0 && !o_conv_done_irq) else $error("write did not abort");
  a_stop_holds: assert property (
    halt_ff |-> !o_sample && o_tap_code == 10'h0 && !o_conv_done_irq) else $error("halt did not stop");
  a_first_tap: assert property (
    o_tap_code != 10'h0 && $past(o_tap_code) == 10'h0 |-> o_tap_code == 10'h200) else $error("first tap wrong");
  a_second_tap: assert property (
    $past(o_tap_code) == 10'h200 && o_tap_code != 10'h200 && o_tap_code != 10'h0
    |-> o_tap_code == {$past(i_cmp_high), 9'h100}) else $error("second tap wrong");
  a_irq_after_lsb: assert property (
    o_conv_done_irq |-> $past(o_tap_code[0])) else $error("irq without bit zero trial");
  a_irq_pulse: assert property (
    o_conv_done_irq |=> !o_conv_done_irq) else $error("irq longer than one cycle");
endmodule // sadc_ctrl_monitor

// [sim/sadc_front_end_model.sv]
// sadc_front_end_model.sv: behavioural sample-hold and comparator
// assumes: bench fills vin_ff per channel; tap code is zero outside trials
module sadc_front_end_model (
  // clock and converter controls
  input wire logic i_ref_clk,
  input wire logic [2:0] i_chan_sel,
  input wire logic i_sample,
  input wire logic [9:0] i_tap_code,
  // comparator decision
  output logic o_cmp_high
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====
  logic [9:0] vin_ff [8];
  logic [9:0] held_ff = 10'h0;
  logic tgl_ff = 1'b0;
  // track input while sampling, hold it afterwards
  always @(posedge i_ref_clk) begin
    tgl_ff <= ~tgl_ff;
    if (i_sample) held_ff <= vin_ff[i_chan_sel];
  end
  // decision is meaningless outside trials, so it toggles there
  assign o_cmp_high = (i_tap_code != 10'h0) ? (held_ff >= i_tap_code) : tgl_ff;
endmodule // sadc_front_end_model

// [sim/sadc_ctrl_bench.sv]
// sadc_ctrl_bench.sv: self-checking bench for the converter control
// assumes: include path reaches logic/, zero-wait bus slave, 10 MHz clock
`include "sadc_defines.vh"
module sadc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // =====
  localparam logic [31:0] adr_mode = 32'(`SADC_ADDR_MODE);
  localparam logic [31:0] adr_chan = 32'(`SADC_ADDR_CHAN);
  localparam logic [31:0] adr_res = 32'(`SADC_ADDR_RESULT);
  localparam logic [31:0] adr_stat = 32'(`SADC_ADDR_STATUS);
  logic clk, srst, hsel, hwrite, trig, hready, hresp, cmp, smp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, chan;
  logic [9:0] tap;
  int num_errors, samples_checked;
  sadc_ctrl u_dut (.i_ref_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_ext_trigger(trig), .i_cmp_high(cmp), .o_chan_sel(chan),
    .o_sample(smp), .o_tap_code(tap), .o_conv_done_irq(irq));
  sadc_front_end_model u_fe (.i_ref_clk(clk), .i_chan_sel(chan), .i_sample(smp), .i_tap_code(tap), .o_cmp_high(cmp));
  // expectations
  function automatic logic [31:0] exp_res(input logic [9:0] v);
    return {16'h0, v, 6'h0};
  endfunction
  function automatic int sample_len(input int k);
    int t[8] = '{144, 120, 96, 144, 72, 60, 48, 144};
    return t[k] / 8;
  endfunction
  // one single-word bus transfer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2; haddr <= a; hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // counts irq pulses and sampling width
  task automatic count_irq(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (irq === 1'b1) c++;
    end
    @(posedge clk);
  endtask
  task automatic wait_sample(output int w);
    int n;
    n = 0;
    w = 0;
    while (smp !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    while (smp === 1'b1) begin
      @(negedge clk);
      w++;
    end
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
  // main sequence
  initial begin
    int i, w, c;
    logic [31:0] q;
    srst = 1'b1; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; trig = 1'b0; num_errors = 0; samples_checked = 0;
    w = $urandom(32'h26003084);
    for (i = 0; i < 8; i++) u_fe.vin_ff[i] = 10'($urandom);
    u_fe.vin_ff[0] = 10'h3ff;
    u_fe.vin_ff[7] = 10'h200;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, adr_mode, 32'h0, q); check(q, 32'h0);
    check({30'h0, hresp, hready}, 32'h1);
    bus(1'b0, adr_chan, 32'h0, q); check(q, 32'h0);
    bus(1'b0, 32'h100, 32'h0, q); check(q, 32'h0);
    w = $urandom;
    bus(1'b1, adr_chan, 32'(w[7:0]), q);
    bus(1'b0, adr_chan, 32'h0, q); check(q, 32'(w[2:0]));
    bus(1'b1, adr_mode, 32'(w[14:8]), q);
    bus(1'b0, adr_mode, 32'h0, q);
    check(q, 32'({w[14:9], 1'b0}));
    $display("test registers done");
    for (i = 0; i < 7; i++) if (i != 3) begin
      bus(1'b1, adr_mode, 32'h80 | 32'(i << 3), q);
      wait_sample(w); check(32'(w), 32'(sample_len(i)));
      bus(1'b1, adr_mode, 32'h0, q);
    end
    $display("test timing done");
    bus(1'b1, adr_mode, 32'hb0, q);
    for (i = 0; i < 8; i++) begin
      bus(1'b1, adr_chan, 32'(i), q);
      count_irq(0, c);
      w = 0;
      while (irq !== 1'b1 && w < 200) begin
        @(negedge clk);
        w++;
      end
      @(posedge clk);
      bus(1'b0, adr_res, 32'h0, q); check(q, exp_res(u_fe.vin_ff[i]));
      count_irq(60, c); check(32'(c), 32'h1);
    end
    bus(1'b1, adr_mode, 32'h30, q);
    count_irq(200, c); check(32'(c), 32'h0);
    $display("test software start done");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, adr_mode, 32'hf0 | 32'(i << 1), q);
      count_irq(100, c); check(32'(c), 32'h0);
      bus(1'b0, adr_stat, 32'h0, q);
      check(q, 32'h1);
      trig <= 1'b1; count_irq(120, c); check(32'(c), 32'(i[1]));
      trig <= 1'b0; count_irq(120, c); check(32'(c), 32'(i[0]));
    end
    trig <= 1'b1; count_irq(20, c);
    trig <= 1'b0; count_irq(150, c); check(32'(c), 32'h1);
    trig <= 1'b1; count_irq(20, c);
    bus(1'b1, adr_chan, 32'h7, q); count_irq(150, c); check(32'(c), 32'h0);
    trig <= 1'b0; count_irq(150, c); check(32'(c), 32'h1);
    bus(1'b0, adr_res, 32'h0, q); check(q, exp_res(u_fe.vin_ff[7]));
    $display("test hardware start done");
    test_done();
  end
endmodule // sadc_ctrl_bench
bind sadc_ctrl sadc_ctrl_monitor u_mon (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready), .i_cmp_high(i_cmp_high),
  .o_chan_sel(o_chan_sel), .o_sample(o_sample), .o_tap_code(o_tap_code), .o_conv_done_irq(o_conv_done_irq));
